// ---- hdl/pfp_port.sv ----
// Purpose: Device side of the parallel flash programming port.
// Assumes: Pins synchronous to clock_in; programmer keeps its own rules.
// Notes: Flash array held in pfp_array.
`timescale 1ns/10ps
`include "pfp_defines.svh"
module pfp_port
(
	// Clock and reset
	input  wire logic        clock_in,
	input  wire logic        rst_n_in,
	// Handshake pins
	input  wire logic        command_strobe_n_pin_in,
	input  wire logic        output_enable_n_pin_in,
	output logic             device_idle_pin_out,
	output logic             output_valid_n_pin_out,
	// Mode and data pins
	input  wire logic [3:0]  word_type_pins_in,
	input  wire logic [15:0] programming_bus_pins_in,
	output logic [15:0]      programming_bus_pins_out,
	output logic             programming_bus_pins_oe_out
);
	typedef struct packed {
		pfp_pkg::pfp_state_t     st;
		pfp_pkg::pfp_kind_t      kind;
		logic [15:0]             cmd;
		logic [31:0]             addr;
		logic [3:0]              mode;
		logic [15:0]             word;
		logic [`PFP_PAGE_WORDS*16-1:0] buf_data;
		logic [`PFP_PAGE_WORDS-1:0]    dirty;
		logic [`PFP_ADDR_W-1:0]  buf_base;
		logic                    buf_lock;
		logic                    buf_erase;
		logic [`PFP_REGIONS-1:0] locks;
		pfp_pkg::pfp_commit_t    commit;
		logic [`PFP_PAGE_WORDS*16-1:0] commit_data;
		logic [`PFP_PAGE_WORDS-1:0]    commit_dirty;
		logic                    erase_all;
		logic                    idle;
		logic                    valid_n;
		logic [15:0]             dout;
		logic                    oe;
	} pfp_regs_t;

	pfp_regs_t   s_q;
	pfp_regs_t   s_d;
	logic [15:0] rdata;

	function automatic logic [`PFP_ADDR_W-1:0] page_of(input logic [31:0] a);
		page_of = {a[`PFP_ADDR_W-1:`PFP_PAGE_BITS], {`PFP_PAGE_BITS{1'b0}}};
	endfunction

	function automatic logic [`PFP_REGIONS-1:0] region_of(input logic [`PFP_ADDR_W-1:0] a);
		region_of = `PFP_REGIONS'(1) << a[`PFP_ADDR_W-1:`PFP_REGION_BITS];
	endfunction

	pfp_array u_array
	(
		.clock_in     (clock_in),
		.rst_n_in     (rst_n_in),
		.commit_in    (s_q.commit),
		.page_in      (s_q.commit_data),
		.dirty_in     (s_q.commit_dirty),
		.erase_all_in (s_q.erase_all),
		.raddr_in     (s_q.addr[`PFP_ADDR_W-1:0]),
		.rdata_out    (rdata)
	);

	always_comb
	begin
		s_d = s_q;
		s_d.commit.start = 1'b0;
		s_d.erase_all = 1'b0;
		unique case (s_q.st)
			pfp_pkg::ST_IDLE:
			begin
				if (!command_strobe_n_pin_in)
				begin
					s_d.mode = word_type_pins_in;
					s_d.word = programming_bus_pins_in;
					s_d.idle = 1'b0;
					s_d.st = pfp_pkg::ST_EXEC;
				end
			end
			pfp_pkg::ST_EXEC:
			begin
				s_d.st = pfp_pkg::ST_WAIT_CMD;
				if (s_q.mode == `PFP_MODE_CMD)
				begin
					// new command completes the previous one
					// commit load buffer on command word
					if (|s_q.dirty)
					begin
						s_d.commit.start = 1'b1;
						s_d.commit.erase_first = s_q.buf_erase;
						s_d.commit.page_base = s_q.buf_base;
						s_d.commit_data = s_q.buf_data;
						s_d.commit_dirty = s_q.dirty;
						if (s_q.buf_lock)
							s_d.locks = s_q.locks | region_of(s_q.buf_base);
						s_d.dirty = '0;
					end
					s_d.cmd = s_q.word;
					unique case (s_q.word)
						`PFP_CMD_READ: s_d.kind = pfp_pkg::FL_READ;
						`PFP_CMD_WP, `PFP_CMD_WPL, `PFP_CMD_EWP, `PFP_CMD_ERASE_WRITE_LOCK_CMD:
							s_d.kind = pfp_pkg::FL_WRITE;
						`PFP_CMD_EA:  s_d.kind = pfp_pkg::FL_EA;
						`PFP_CMD_SLB: s_d.kind = pfp_pkg::FL_SLB;
						`PFP_CMD_CLB: s_d.kind = pfp_pkg::FL_CLB;
						`PFP_CMD_GLB: s_d.kind = pfp_pkg::FL_GLB;
						default:      s_d.kind = pfp_pkg::FL_NONE;
					endcase
				end
				else if (s_q.mode == `PFP_MODE_MODE_ADDRESS_WORD_LOW)
					s_d.addr[15:0] = s_q.word;
				else if (s_q.mode == `PFP_MODE_MODE_ADDRESS_WORD_1)
					s_d.addr[31:16] = s_q.word;
				else if (s_q.mode == `PFP_MODE_MODE_ADDRESS_WORD_2)
					s_d.addr[31:16] = s_q.word;
				else if (s_q.mode == `PFP_MODE_MODE_ADDRESS_WORD_HIGH)
					s_d.addr[31:16] = s_q.word;
				else if (s_q.mode == `PFP_MODE_DATA)
				begin
					unique case (s_q.kind)
						pfp_pkg::FL_READ, pfp_pkg::FL_GLB:
						begin
							if (|s_q.dirty && page_of(s_q.addr) != s_q.buf_base)
							begin
								s_d.commit.start = 1'b1;
								s_d.commit.erase_first = s_q.buf_erase;
								s_d.commit.page_base = s_q.buf_base;
								s_d.commit_data = s_q.buf_data;
								s_d.commit_dirty = s_q.dirty;
								s_d.dirty = '0;
							end
							s_d.st = pfp_pkg::ST_WAIT_OE;
						end
						pfp_pkg::FL_WRITE:
						begin
							// commit before a write to another page
							if (|s_q.dirty && page_of(s_q.addr) != s_q.buf_base)
							begin
								s_d.commit.start = 1'b1;
								s_d.commit.erase_first = s_q.buf_erase;
								s_d.commit.page_base = s_q.buf_base;
								s_d.commit_data = s_q.buf_data;
								s_d.commit_dirty = s_q.dirty;
								if (s_q.buf_lock)
									s_d.locks = s_q.locks | region_of(s_q.buf_base);
								s_d.dirty = `PFP_PAGE_WORDS'(0);
							end
							s_d.buf_base = page_of(s_q.addr);
							// lock after write for lock variants
							s_d.buf_lock = (s_q.cmd == `PFP_CMD_WPL) ||
								(s_q.cmd == `PFP_CMD_ERASE_WRITE_LOCK_CMD);
							// erase variants erase the page first
							s_d.buf_erase = (s_q.cmd == `PFP_CMD_EWP) ||
								(s_q.cmd == `PFP_CMD_ERASE_WRITE_LOCK_CMD);
							s_d.buf_data[s_q.addr[`PFP_PAGE_BITS-1:0]*16 +: 16] = s_q.word;
							s_d.dirty[s_q.addr[`PFP_PAGE_BITS-1:0]] = 1'b1;
							s_d.addr = s_q.addr + 32'h0000_0001;
						end
						pfp_pkg::FL_EA:
						begin
							// full erase on a zero data word
							// abort when any region is locked
							if (s_q.word == `PFP_ZERO16 && s_q.locks == '0)
							begin
								s_d.erase_all = 1'b1;
								s_d.dirty = '0;
							end
						end
						pfp_pkg::FL_SLB: s_d.locks = s_q.locks | s_q.word[`PFP_REGIONS-1:0];
						pfp_pkg::FL_CLB: s_d.locks = s_q.locks & ~s_q.word[`PFP_REGIONS-1:0];
						default: ;
					endcase
				end
			end
			pfp_pkg::ST_WAIT_OE:
			begin
				// output enable low turns bus to output
				if (!output_enable_n_pin_in)
				begin
					s_d.oe = 1'b1;
					// lock status answers a get-lock read
					if (s_q.kind == pfp_pkg::FL_GLB)
						s_d.dout = {{(16-`PFP_REGIONS){1'b0}}, s_q.locks};
					else if (|s_q.dirty && page_of(s_q.addr) == s_q.buf_base &&
						s_q.dirty[s_q.addr[`PFP_PAGE_BITS-1:0]])
						s_d.dout = s_q.buf_data[s_q.addr[`PFP_PAGE_BITS-1:0]*16 +: 16];
					else
						s_d.dout = rdata;
					s_d.st = pfp_pkg::ST_DRIVE;
				end
			end
			pfp_pkg::ST_DRIVE:
			begin
				// valid low after data is on the bus
				s_d.valid_n = 1'b0;
				s_d.st = pfp_pkg::ST_VALID;
			end
			pfp_pkg::ST_VALID:
			begin
				// release bus when output enable rises
				if (output_enable_n_pin_in)
				begin
					s_d.oe = 1'b0;
					s_d.st = pfp_pkg::ST_RELEASE;
				end
			end
			pfp_pkg::ST_RELEASE:
			begin
				s_d.valid_n = 1'b1;
				if (s_q.kind == pfp_pkg::FL_READ)
					s_d.addr = s_q.addr + 32'h0000_0001;
				s_d.st = pfp_pkg::ST_WAIT_CMD;
			end
			pfp_pkg::ST_WAIT_CMD:
			begin
				// idle returns only after strobe is high
				if (command_strobe_n_pin_in)
				begin
					s_d.idle = 1'b1;
					s_d.st = pfp_pkg::ST_IDLE;
				end
			end
		endcase
		if (!rst_n_in)
		begin
			s_d = '0;
			s_d.st = pfp_pkg::ST_IDLE;
			s_d.idle = 1'b1;
			s_d.valid_n = 1'b1;
		end
	end

	always_ff @(posedge clock_in)
	begin
		s_q <= s_d;
	end

	assign device_idle_pin_out = s_q.idle;
	assign output_valid_n_pin_out = s_q.valid_n;
	assign programming_bus_pins_out = s_q.dout;
	assign programming_bus_pins_oe_out = s_q.oe;

	// bus input and valid high outside data phase
	a_bus_idle_valid: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		!s_q.oe && !$past(s_q.oe) |-> s_q.valid_n) else $error("Valid low while bus released.");
	// valid falls one cycle after bus is driven
	a_valid_after_drive: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		$fell(s_q.valid_n) |-> s_q.oe && $past(s_q.oe)) else $error("Valid before data.");
	a_release_order: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		$fell(s_q.oe) |=> $rose(s_q.valid_n)) else $error("Valid not raised after release.");
	// idle drops one cycle after strobe in idle
	a_idle_drop: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		s_q.st == pfp_pkg::ST_IDLE && !command_strobe_n_pin_in |=> !s_q.idle)
		else $error("Idle not dropped.");
	// idle rises only with strobe high
	a_idle_rise: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		$rose(s_q.idle) |-> $past(command_strobe_n_pin_in)) else $error("Idle early.");
	a_erase_locked: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		s_q.erase_all |-> $past(s_q.locks) == '0) else $error("Erase with locks set.");
	// command word commits a dirty buffer
	a_cmd_commit: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		s_q.st == pfp_pkg::ST_EXEC && s_q.mode == `PFP_MODE_CMD && |s_q.dirty
		|=> s_q.commit.start) else $error("No commit on command.");
	// write data advances address by one
	a_write_incr: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		s_q.st == pfp_pkg::ST_EXEC && s_q.mode == `PFP_MODE_DATA &&
		s_q.kind == pfp_pkg::FL_WRITE |=> s_q.addr == $past(s_q.addr) + 32'h0000_0001)
		else $error("Address not advanced.");
	// idle held low while strobe stays low
	a_idle_hold: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		!s_q.idle && !command_strobe_n_pin_in |=> !s_q.idle)
		else $error("Idle raised while strobe low.");
	// bus driven after output enable seen low
	a_drive_on_oe: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		s_q.st == pfp_pkg::ST_WAIT_OE && !output_enable_n_pin_in |=> s_q.oe)
		else $error("Bus not driven after output enable.");
	a_lock_set: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		s_q.st == pfp_pkg::ST_EXEC && s_q.mode == `PFP_MODE_DATA &&
		s_q.kind == pfp_pkg::FL_SLB |=> (s_q.locks & $past(s_q.word[`PFP_REGIONS-1:0]))
		== $past(s_q.word[`PFP_REGIONS-1:0])) else $error("Lock mask not set.");
	a_lock_clear: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		s_q.st == pfp_pkg::ST_EXEC && s_q.mode == `PFP_MODE_DATA &&
		s_q.kind == pfp_pkg::FL_CLB |=> (s_q.locks & $past(s_q.word[`PFP_REGIONS-1:0]))
		== '0) else $error("Lock mask not cleared.");
	c_read: cover property (@(posedge clock_in) disable iff (!rst_n_in)
		$rose(s_q.valid_n) && s_q.kind == pfp_pkg::FL_READ);
	c_commit: cover property (@(posedge clock_in) disable iff (!rst_n_in) s_q.commit.start);
	c_erase: cover property (@(posedge clock_in) disable iff (!rst_n_in) s_q.erase_all);
	c_lock_query: cover property (@(posedge clock_in) disable iff (!rst_n_in)
		s_q.st == pfp_pkg::ST_DRIVE && s_q.kind == pfp_pkg::FL_GLB);
	c_erase_abort: cover property (@(posedge clock_in) disable iff (!rst_n_in)
		s_q.st == pfp_pkg::ST_EXEC && s_q.mode == `PFP_MODE_DATA &&
		s_q.kind == pfp_pkg::FL_EA && |s_q.locks);
endmodule // pfp_port

// ---- hdl/pfp_defines.svh ----
// Purpose: Constants for the parallel flash programming port.
// Assumes: 16-bit programming bus, 40 MHz clock.
// Notes: Operation list below.
// Operation
// - Handshake starts with strobe low when idle; ends when strobe and idle high.
// - Mode field selects command, four address words, data, or nothing.
// - Command-mode word is stored as one of nine command codes.
// - After output enable falls, drive bus with flash data, then valid low.
// - When output enable rises, release bus, then raise valid.
// - A new command completes the previous one, committing pending page buffer.
// - Flash read is command, address words, then chained read handshakes.
// - Address pointer advances after each read; address reload allowed anytime.
// - Written data go to a page-sized load buffer, not the array.
// - Load buffer is committed before access to another page.
// - Load buffer is committed when a command-mode word is accepted.
// - Page write is write command, address, data words; address increments.
// - Write-and-lock sets region lock bit after the flash write.
// - Erase variants erase the page before programming; lock variant also locks.
// - Full erase is command plus one data word of zero.
// - Full erase aborts if any region is locked.
// - Set-lock data word is a mask; bit n locks region n.
// - Clear-lock data word is a mask; set bits unlock regions.
// - Get-lock answers one read with the lock status mask.
`ifndef PFP_DEFINES_SVH
`define PFP_DEFINES_SVH
`define PFP_MODE_CMD      4'h0
`define PFP_MODE_MODE_ADDRESS_WORD_LOW    4'h1
`define PFP_MODE_MODE_ADDRESS_WORD_1    4'h2
`define PFP_MODE_MODE_ADDRESS_WORD_2    4'h3
`define PFP_MODE_MODE_ADDRESS_WORD_HIGH    4'h4
`define PFP_MODE_DATA     4'h5
`define PFP_CMD_READ      16'h0011
`define PFP_CMD_WP        16'h0012
`define PFP_CMD_WPL       16'h0022
`define PFP_CMD_EWP       16'h0032
`define PFP_CMD_ERASE_WRITE_LOCK_CMD      16'h0042
`define PFP_CMD_EA        16'h0013
`define PFP_CMD_SLB       16'h0014
`define PFP_CMD_CLB       16'h0024
`define PFP_CMD_GLB       16'h0015
`define PFP_ADDR_W        12
`define PFP_PAGE_BITS     4
`define PFP_PAGE_WORDS    16
`define PFP_REGION_BITS   8
`define PFP_REGIONS       4
`define PFP_ERASED        16'hffff
`define PFP_ZERO16        16'h0000
`endif

// ---- hdl/pfp_pkg.sv ----
// Purpose: Types for the parallel flash programming port.
// Assumes: pfp_defines.svh constants.
// Notes: None.
`include "pfp_defines.svh"
package pfp_pkg;
	typedef enum logic [2:0] {
		ST_IDLE, ST_EXEC, ST_WAIT_OE, ST_DRIVE, ST_VALID, ST_RELEASE, ST_WAIT_CMD
	} pfp_state_t;
	typedef enum logic [2:0] {
		FL_NONE, FL_READ, FL_WRITE, FL_EA, FL_SLB, FL_CLB, FL_GLB
	} pfp_kind_t;
	typedef struct packed {
		logic                   start;
		logic                   erase_first;
		logic [`PFP_ADDR_W-1:0] page_base;
	} pfp_commit_t;
endpackage

// ---- hdl/pfp_array.sv ----
// Purpose: Flash array model with page commit from the load buffer.
// Assumes: Commit takes one clock.
// Notes: Read is combinational from the array.
`timescale 1ns/10ps
`include "pfp_defines.svh"
module pfp_array
(
	// Clock and reset
	input  wire logic                   clock_in,
	input  wire logic                   rst_n_in,
	// Commit request, page data and erase-all request
	input  wire pfp_pkg::pfp_commit_t   commit_in,
	input  wire logic [`PFP_PAGE_WORDS*16-1:0] page_in,
	input  wire logic [`PFP_PAGE_WORDS-1:0]    dirty_in,
	input  wire logic                   erase_all_in,
	// Read port
	input  wire logic [`PFP_ADDR_W-1:0] raddr_in,
	output logic [15:0]                 rdata_out
);
	logic [15:0] mem_q [0:(1<<`PFP_ADDR_W)-1];
	integer i;
	always_ff @(posedge clock_in)
	begin
		if (erase_all_in)
		begin
			for (i = 0; i < (1<<`PFP_ADDR_W); i = i + 1)
				mem_q[i] <= `PFP_ERASED;
		end
		else if (commit_in.start)
		begin
			for (i = 0; i < `PFP_PAGE_WORDS; i = i + 1)
			begin
				if (dirty_in[i])
					mem_q[commit_in.page_base + i[`PFP_ADDR_W-1:0]] <= page_in[i*16 +: 16];
				else if (commit_in.erase_first)
					mem_q[commit_in.page_base + i[`PFP_ADDR_W-1:0]] <= `PFP_ERASED;
			end
		end
	end
	assign rdata_out = mem_q[raddr_in];
endmodule // pfp_array

// ---- dv/pfp_programmer.sv ----
// Purpose: Programmer model that drives the parallel flash programming port.
// Assumes: Pins change at rising edges; device answers are sampled 1 ns later.
// Notes: A released bus shows the inverse of the last word driven.
`timescale 1ns/10ps
module pfp_programmer
(
	// Clock
	input  wire logic        clock_in,
	// Device answers
	input  wire logic        idle_in,
	input  wire logic        valid_n_in,
	input  wire logic        bus_oe_in,
	input  wire logic [15:0] bus_dout_in,
	// Programmer drives
	output logic             strobe_n_out,
	output logic             oe_n_out,
	output logic [3:0]       mode_out,
	output logic [15:0]      bus_out,
	output int               hangs_out
);
	logic        drive_q;
	logic [15:0] word_q;
	initial
	begin
		strobe_n_out = 1'b1;
		oe_n_out = 1'b1;
		mode_out = 4'hf;
		drive_q = 1'b1;
		word_q = 16'h0000;
		hangs_out = 0;
	end
	assign bus_out = bus_oe_in ? bus_dout_in : (drive_q ? word_q : ~word_q);
	task automatic wait_for(input bit on_valid, input logic lvl);
		int n;
		for (n = 0; n < 64; n++)
		begin
			@(posedge clock_in);
			#1;
			if ((on_valid ? valid_n_in : idle_in) === lvl)
				return;
		end
		hangs_out++;
	endtask
	// strobe, wait idle low, raise strobe, wait idle.
	task automatic write_hs(input logic [3:0] m, input logic [15:0] d);
		@(posedge clock_in);
		mode_out <= m;
		word_q <= d;
		drive_q <= 1'b1;
		strobe_n_out <= 1'b0;
		wait_for(1'b0, 1'b0);
		@(posedge clock_in);
		strobe_n_out <= 1'b1;
		mode_out <= 4'hf;
		drive_q <= 1'b0;
		wait_for(1'b0, 1'b1);
	endtask
	// release bus, sample after valid low, resume.
	task automatic read_hs(output logic [15:0] d);
		@(posedge clock_in);
		mode_out <= 4'h5;
		drive_q <= 1'b1;
		strobe_n_out <= 1'b0;
		wait_for(1'b0, 1'b0);
		@(posedge clock_in);
		drive_q <= 1'b0;
		@(posedge clock_in);
		oe_n_out <= 1'b0;
		wait_for(1'b1, 1'b0);
		d = bus_out;
		@(posedge clock_in);
		oe_n_out <= 1'b1;
		wait_for(1'b1, 1'b1);
		@(posedge clock_in);
		drive_q <= 1'b1;
		strobe_n_out <= 1'b1;
		mode_out <= 4'hf;
		wait_for(1'b0, 1'b1);
	endtask
endmodule // pfp_programmer

// ---- dv/pfp_port_tb.sv ----
// Purpose: Self-checking bench for the parallel flash programming port.
// Assumes: 40 MHz clock, 12-bit word address, four lock regions.
// Notes: Each scenario is its own task.
`timescale 1ns/10ps
module pfp_port_tb;
	logic        clock_in;
	logic        rst_n_in;
	logic        strobe_n;
	logic        oe_n;
	logic        idle;
	logic        valid_n;
	logic [3:0]  mode;
	logic [15:0] bus_in;
	logic [15:0] dout;
	logic        bus_oe;
	int          hangs;
	int          mismatches;
	int          total_checks;
	pfp_port pfp_port_i (.clock_in(clock_in), .rst_n_in(rst_n_in),
		.command_strobe_n_pin_in(strobe_n), .output_enable_n_pin_in(oe_n),
		.device_idle_pin_out(idle), .output_valid_n_pin_out(valid_n),
		.word_type_pins_in(mode), .programming_bus_pins_in(bus_in),
		.programming_bus_pins_out(dout), .programming_bus_pins_oe_out(bus_oe));
	pfp_programmer pfp_programmer_i (.clock_in(clock_in), .idle_in(idle),
		.valid_n_in(valid_n), .bus_oe_in(bus_oe), .bus_dout_in(dout),
		.strobe_n_out(strobe_n), .oe_n_out(oe_n), .mode_out(mode),
		.bus_out(bus_in), .hangs_out(hangs));
	initial
	begin
		clock_in = 1'b0;
		forever #12.5 clock_in = ~clock_in;
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic end_of_test();
		mismatches += hangs;
		$display("checks=%0d mismatches=%0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic cmd(input logic [15:0] c);
		pfp_programmer_i.write_hs(4'h0, c);
	endtask
	task automatic addr(input logic [15:0] a);
		pfp_programmer_i.write_hs(4'h1, a);
		pfp_programmer_i.write_hs(4'h2, 16'h0000);
	endtask
	task automatic wr(input logic [15:0] d);
		pfp_programmer_i.write_hs(4'h5, d);
	endtask
	task automatic rd_chk(input logic [15:0] exp);
		logic [15:0] d;
		pfp_programmer_i.read_hs(d);
		check(d, exp);
		check({14'h0, bus_oe, valid_n}, 16'h0001);
	endtask
	task automatic read_at(input logic [15:0] a, input logic [15:0] exp);
		cmd(`PFP_CMD_READ);
		addr(a);
		rd_chk(exp);
	endtask
	task automatic t_reset();
		check({13'h0, idle, valid_n, bus_oe}, 16'h0006);
	endtask
	task automatic t_full_erase();
		cmd(`PFP_CMD_EA);
		wr(16'h0000);
		read_at(16'h0000, `PFP_ERASED);
		rd_chk(`PFP_ERASED);
	endtask
	task automatic t_page_write();
		cmd(`PFP_CMD_WP);
		addr(16'h001e);
		wr(16'h1111);
		wr(16'h2222);
		pfp_programmer_i.write_hs(4'h6, 16'h0bad);
		wr(16'h3333);
		wr(16'h4444);
		cmd(`PFP_CMD_READ);
		addr(16'h001e);
		rd_chk(16'h1111);
		rd_chk(16'h2222);
		rd_chk(16'h3333);
		rd_chk(16'h4444);
		addr(16'h001f);
		rd_chk(16'h2222);
		pfp_programmer_i.write_hs(4'h3, 16'h1234);
		pfp_programmer_i.write_hs(4'h4, 16'habcd);
		rd_chk(16'h3333);
	endtask
	task automatic t_erase_write();
		cmd(`PFP_CMD_WP);
		addr(16'h0031);
		wr(16'haaaa);
		cmd(`PFP_CMD_EWP);
		addr(16'h0030);
		wr(16'h5555);
		read_at(16'h0030, 16'h5555);
		rd_chk(`PFP_ERASED);
	endtask
	task automatic t_write_lock();
		// plain write first, write-and-lock last page of region 1.
		cmd(`PFP_CMD_WP);
		addr(16'h0100);
		wr(16'h7777);
		cmd(`PFP_CMD_GLB);
		rd_chk(16'h0000);
		cmd(`PFP_CMD_WPL);
		addr(16'h01f0);
		wr(16'h7778);
		cmd(`PFP_CMD_GLB);
		rd_chk(16'h0002);
		read_at(16'h0100, 16'h7777);
		rd_chk(`PFP_ERASED);
		cmd(`PFP_CMD_ERASE_WRITE_LOCK_CMD);
		addr(16'h0200);
		wr(16'h8888);
		cmd(`PFP_CMD_GLB);
		rd_chk(16'h0006);
		read_at(16'h0200, 16'h8888);
	endtask
	task automatic t_lock_bits();
		cmd(`PFP_CMD_SLB);
		wr(16'h0009);
		cmd(`PFP_CMD_GLB);
		rd_chk(16'h000f);
		cmd(`PFP_CMD_CLB);
		wr(16'h0003);
		cmd(`PFP_CMD_GLB);
		rd_chk(16'h000c);
		cmd(`PFP_CMD_EA);
		wr(16'h0000);
		read_at(16'h001e, 16'h1111);
		cmd(`PFP_CMD_CLB);
		wr(16'h000f);
		cmd(`PFP_CMD_GLB);
		rd_chk(16'h0000);
		cmd(`PFP_CMD_EA);
		wr(16'h0000);
		read_at(16'h001e, `PFP_ERASED);
	endtask
	initial
	begin
		mismatches = 0;
		total_checks = 0;
		rst_n_in = 1'b0;
		repeat (10) @(posedge clock_in);
		rst_n_in <= 1'b1;
		@(posedge clock_in);
		#1;
		t_reset();
		t_full_erase();
		t_page_write();
		t_erase_write();
		t_write_lock();
		t_lock_bits();
		end_of_test();
	end
	initial
	begin
		repeat (40000) @(posedge clock_in);
		mismatches++;
		end_of_test();
	end
endmodule // pfp_port_tb
